// ### src/twr_defines.svh
// Constants for the two-wire register read slave.
// Assumes inclusion by bare name from the design files under src/.
`ifndef TWR_DEFINES_SVH
`define TWR_DEFINES_SVH

// ----------------------------------------------------------------------------
// Bus address and data constants
// ----------------------------------------------------------------------------
`define TWR_DEV_ADDR     7'h36
`define TWR_FILL_BYTE    8'hFF
`define TWR_PTR_RESET    9'h000
`define TWR_BYTE_BITS    4'h8

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define TWR_CLK_NS       100
`define TWR_SCL_MAX_KHZ  400
`define TWR_SCL_MIN_CYC  ((1000000 / `TWR_SCL_MAX_KHZ) / `TWR_CLK_NS)

`endif

// ### src/twr_pkg.sv
// Types shared by the two-wire register read slave.
// Assumes nothing of its surroundings.
package twr_pkg;

  // --------------------------------------------------------------------------
  // Protocol states
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_SACK,
    ST_PTR,
    ST_WDATA,
    ST_TX,
    ST_MACK
  } twr_state_t;

endpackage

// ### src/twr_fifo_if.sv
// Byte stream between the fetch logic and the two-entry buffer.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface twr_fifo_if #(parameter int W = 8);
  logic         flush;
  logic         push_valid;
  logic         push_ready;
  logic [W-1:0] push_data;
  logic         pop_valid;
  logic         pop_ready;
  logic [W-1:0] pop_data;

  modport buffer (input flush, push_valid, push_data, pop_ready,
                  output push_ready, pop_valid, pop_data);
  modport user   (output flush, push_valid, push_data, pop_ready,
                  input push_ready, pop_valid, pop_data);
endinterface

// ### src/twr_fifo.sv
// Two-entry flip-flop buffer with valid and ready on both sides.
// Assumes a synchronous active-low reset on the same clock as its user.
`timescale 1ns/1ps
module twr_fifo #(
  parameter int W = 8,
  parameter int D = 2
) (
  input  wire logic clk_sys_i,
  input  wire logic resetn_i,
  twr_fifo_if.buffer f
);
  localparam int AW = (D > 1) ? $clog2(D) : 1;

  logic [W-1:0] mem [D];
  logic [AW-1:0] wr_idx;
  logic [AW-1:0] rd_idx;
  logic [AW:0]   count;
  logic          do_push;
  logic          do_pop;

  assign f.push_ready = (count != (AW+1)'(D));
  assign f.pop_valid  = (count != '0);
  assign f.pop_data   = mem[rd_idx];
  assign do_push      = f.push_valid && f.push_ready && !f.flush;
  assign do_pop       = f.pop_valid && f.pop_ready && !f.flush;

  // --------------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < D; gi++) begin : g_entry
      always_ff @(posedge clk_sys_i) begin
        if (!resetn_i) begin
          mem[gi] <= '0;
        end else if (do_push && wr_idx == AW'(gi)) begin
          mem[gi] <= f.push_data;
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // Pointers
  // --------------------------------------------------------------------------
  // Flush wins so a new read never sees bytes fetched for the old pointer.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i || f.flush) begin
      wr_idx <= '0;
      rd_idx <= '0;
      count  <= '0;
    end else begin
      if (do_push) begin
        wr_idx <= (wr_idx == AW'(D-1)) ? '0 : wr_idx + 1'b1;
      end
      if (do_pop) begin
        rd_idx <= (rd_idx == AW'(D-1)) ? '0 : rd_idx + 1'b1;
      end
      count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule

// ### src/twr_read_slave.sv
// Two-wire slave that serves register reads from a word-wide register space.
// Assumes scl_i and sda_i come from pins; reg_rdata_i answers reg_word_o
// in the same cycle from logic on clk_sys_i.
//
// How it works
// - Write pointer, repeated START, read address, bytes.
// - First byte is MSB at the pointer.
// - Pointer advances after each sent byte.
// - Past top address every byte is FFh.
// - Reserved locations return whatever the space gives.
// - Answer only the fixed seven-bit address.
// - Drive data line except master acknowledge cycles.
// - Even address holds upper byte, odd lower.
// - Acknowledge holds data low through ninth clock.
`timescale 1ns/1ps
`include "twr_defines.svh"
module twr_read_slave (
  input  wire logic       clk_sys_i,
  input  wire logic       resetn_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  output logic [6:0]      reg_word_o,
  input  wire logic [15:0] reg_rdata_i
);
  twr_pkg::twr_state_t st;
  twr_pkg::twr_state_t ack_to;
  logic       scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  logic       scl_rise, scl_fall, bus_start, bus_stop, byte_end, addr_hit;
  logic [3:0] bitcnt;
  logic [7:0] shreg;
  logic [7:0] txsh;
  logic       nak;
  logic [8:0] ptr;
  logic [8:0] fptr;
  logic       load;
  logic [7:0] load_byte;
  logic       read_go;
  logic       fetch_on;
  logic [7:0] hold_lo;
  logic [6:0] hold_idx;
  logic       hold_ok;
  logic       use_hold;

  twr_fifo_if #(.W(8)) bq ();

  twr_fifo #(.W(8), .D(2)) u_buf (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .f         (bq)
  );

  // --------------------------------------------------------------------------
  // Pin synchronisers and bus events
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      {scl_m, scl_s, scl_d} <= 3'h7;
      {sda_m, sda_s, sda_d} <= 3'h7;
    end else begin
      {scl_m, scl_s, scl_d} <= {scl_i, scl_m, scl_s};
      {sda_m, sda_s, sda_d} <= {sda_i, sda_m, sda_s};
    end
  end

  assign scl_rise  = scl_s && !scl_d;
  assign scl_fall  = !scl_s && scl_d;
  assign bus_start = scl_s && scl_d && sda_d && !sda_s;
  assign bus_stop  = scl_s && scl_d && !sda_d && sda_s;
  assign byte_end  = scl_fall && (bitcnt == `TWR_BYTE_BITS);
  assign addr_hit  = (shreg[7:1] == `TWR_DEV_ADDR);
  assign read_go   = (st == twr_pkg::ST_ADDR) && byte_end && addr_hit && shreg[0];
  assign load      = scl_fall && !bus_start && !bus_stop &&
                     (((st == twr_pkg::ST_SACK) && (ack_to == twr_pkg::ST_TX)) ||
                      ((st == twr_pkg::ST_MACK) && !nak));
  // An empty buffer cannot happen at bus speed; all-ones is the safe answer.
  assign load_byte = bq.pop_valid ? bq.pop_data : `TWR_FILL_BYTE;
  assign bq.pop_ready = load;

  // --------------------------------------------------------------------------
  // Protocol engine and data line
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      st       <= twr_pkg::ST_IDLE;
      ack_to   <= twr_pkg::ST_PTR;
      bitcnt   <= '0;
      shreg    <= '0;
      txsh     <= '0;
      nak      <= 1'b0;
      sda_o    <= 1'b1;
      sda_oe_o <= 1'b0;
    end else if (bus_start) begin
      st       <= twr_pkg::ST_ADDR;
      bitcnt   <= '0;
      sda_oe_o <= 1'b0;
    end else if (bus_stop) begin
      st       <= twr_pkg::ST_IDLE;
      sda_oe_o <= 1'b0;
    end else begin
      unique case (st)
        twr_pkg::ST_IDLE: begin
        end
        twr_pkg::ST_ADDR, twr_pkg::ST_PTR, twr_pkg::ST_WDATA: begin
          if (scl_rise) begin
            shreg  <= {shreg[6:0], sda_s};
            bitcnt <= bitcnt + 4'h1;
          end else if (byte_end) begin
            bitcnt <= '0;
            if (st == twr_pkg::ST_ADDR && !addr_hit) begin
              st <= twr_pkg::ST_IDLE;
            end else begin
              st       <= twr_pkg::ST_SACK;
              sda_oe_o <= 1'b1;
              sda_o    <= 1'b0;
              if (st != twr_pkg::ST_ADDR) begin
                ack_to <= twr_pkg::ST_WDATA;
              end else begin
                ack_to <= shreg[0] ? twr_pkg::ST_TX : twr_pkg::ST_PTR;
              end
            end
          end
        end
        twr_pkg::ST_SACK: begin
          if (load) begin
            st     <= twr_pkg::ST_TX;
            sda_o  <= load_byte[7];
            txsh   <= {load_byte[6:0], 1'b0};
            bitcnt <= '0;
          end else if (scl_fall) begin
            st       <= ack_to;
            sda_oe_o <= 1'b0;
            bitcnt   <= '0;
          end
        end
        twr_pkg::ST_TX: begin
          if (scl_rise) begin
            bitcnt <= bitcnt + 4'h1;
          end else if (byte_end) begin
            st       <= twr_pkg::ST_MACK;
            sda_oe_o <= 1'b0;
            bitcnt   <= '0;
          end else if (scl_fall) begin
            sda_o <= txsh[7];
            txsh  <= {txsh[6:0], 1'b0};
          end
        end
        twr_pkg::ST_MACK: begin
          if (scl_rise) begin
            nak <= sda_s;
          end else if (load) begin
            st       <= twr_pkg::ST_TX;
            sda_oe_o <= 1'b1;
            sda_o    <= load_byte[7];
            txsh     <= {load_byte[6:0], 1'b0};
          end else if (scl_fall) begin
            st <= twr_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Register pointer
  // --------------------------------------------------------------------------
  // Bit 8 marks a pointer past the top; it sticks there until rewritten.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      ptr <= `TWR_PTR_RESET;
    end else if (st == twr_pkg::ST_PTR && byte_end) begin
      ptr <= {1'b0, shreg};
    end else if ((st == twr_pkg::ST_TX || st == twr_pkg::ST_WDATA) && byte_end &&
                 !ptr[8]) begin
      ptr <= ptr + 9'h001;
    end
  end

  // --------------------------------------------------------------------------
  // Byte fetch into the buffer
  // --------------------------------------------------------------------------
  assign fetch_on = (st == twr_pkg::ST_SACK || st == twr_pkg::ST_TX ||
                     st == twr_pkg::ST_MACK) && (ack_to == twr_pkg::ST_TX);
  assign use_hold = hold_ok && (hold_idx == fptr[7:1]);
  assign bq.flush = read_go || bus_start || bus_stop;
  assign bq.push_valid = fetch_on && (fptr[8] || reg_word_o == fptr[7:1]);
  always_comb begin
    if (fptr[8]) begin
      bq.push_data = `TWR_FILL_BYTE;
    end else if (!fptr[0]) begin
      bq.push_data = reg_rdata_i[15:8];
    end else begin
      bq.push_data = use_hold ? hold_lo : reg_rdata_i[7:0];
    end
  end

  // Reserved words pass through unchecked; their value is whatever the space gives.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      fptr       <= `TWR_PTR_RESET;
      reg_word_o <= '0;
    end else begin
      reg_word_o <= fptr[7:1];
      if (read_go) begin
        fptr <= ptr;
      end else if (bq.push_valid && bq.push_ready && !fptr[8]) begin
        fptr <= fptr + 9'h001;
      end
    end
  end

  // The lower byte is frozen with the upper so a live update cannot tear a word.
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i || read_go) begin
      hold_ok  <= 1'b0;
      hold_lo  <= '0;
      hold_idx <= '0;
    end else if (bq.push_valid && bq.push_ready && !fptr[8] && !fptr[0]) begin
      hold_ok  <= 1'b1;
      hold_lo  <= reg_rdata_i[7:0];
      hold_idx <= fptr[7:1];
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  property p_addr_miss;
    (st == twr_pkg::ST_ADDR && byte_end && !addr_hit && !bus_start && !bus_stop)
      |=> (st == twr_pkg::ST_IDLE) && !sda_oe_o;
  endproperty
  a_addr_miss: assert property (p_addr_miss) else $error("Foreign address answered.");

  property p_sack_low;
    (st == twr_pkg::ST_SACK) |-> sda_oe_o && !sda_o;
  endproperty
  a_sack_low: assert property (p_sack_low) else $error("Acknowledge not held low.");

  property p_tx_drive;
    (st == twr_pkg::ST_TX) |-> sda_oe_o;
  endproperty
  a_tx_drive: assert property (p_tx_drive) else $error("Data line released in a byte.");

  property p_mack_free;
    (st == twr_pkg::ST_MACK) |-> !sda_oe_o;
  endproperty
  a_mack_free: assert property (p_mack_free) else $error("Master acknowledge overdriven.");

  property p_ptr_step;
    (st == twr_pkg::ST_TX && byte_end && !bus_start && !bus_stop && !ptr[8])
      |=> ptr == $past(ptr) + 9'h001;
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("Pointer did not advance.");

  property p_load_msb;
    (load && !bus_start) |=> sda_o == $past(load_byte[7]) && sda_oe_o;
  endproperty
  a_load_msb: assert property (p_load_msb) else $error("Byte not sent MSB first.");

  // Seen at the data line, so the whole buffer path stands behind the check.
  property p_fill;
    (load && ptr[8]) |=> sda_o && sda_oe_o;
  endproperty
  a_fill: assert property (p_fill) else $error("Past-end byte not all ones.");

  property p_hold;
    (bq.push_valid && bq.push_ready && !fptr[8] && !fptr[0] && !read_go)
      ##1 (bq.push_valid && bq.push_ready && fptr[0] && !read_go)
      |-> bq.push_data == $past(reg_rdata_i[7:0]);
  endproperty
  a_hold: assert property (p_hold) else $error("Lower byte from a later sample.");

  property p_start;
    bus_start |=> st == twr_pkg::ST_ADDR && !sda_oe_o;
  endproperty
  a_start: assert property (p_start) else $error("START not honoured.");

  c_read:  cover property (read_go ##[1:1000] load);
  c_nak:   cover property (st == twr_pkg::ST_MACK && nak && scl_fall);
  c_wrap:  cover property (bq.push_valid && fptr[8]);
  c_hold:  cover property (bq.push_valid && bq.push_ready && use_hold);
endmodule

// ### bench/twr_bus_master.sv
// Bus master model that drives the clock line and pulls the data line low.
// Assumes the testbench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ps
module twr_bus_master #(
  parameter int HP = 13
) (
  input  wire logic clk_sys_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_low_o
);
  // ---------------------------------------------------------------------------
  // Bus conditions and bits
  // ---------------------------------------------------------------------------
  // Half period of 13 cycles keeps the clock at or below 400 kHz.
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  // Data moves a few cycles after the clock falls, so it never looks like a START.
  task automatic bit_x(input logic b, output logic s);
    wt(3);
    sda_low_o <= ~b;
    wt(HP - 3);
    scl_o <= 1'b1;
    wt(HP / 2);
    s = sda_i;
    wt(HP - HP / 2);
    scl_o <= 1'b0;
  endtask

  task automatic start_c();
    wt(3);
    sda_low_o <= 1'b0;
    wt(HP);
    scl_o <= 1'b1;
    wt(HP);
    sda_low_o <= 1'b1;
    wt(HP);
    scl_o <= 1'b0;
  endtask

  task automatic stop_c();
    wt(3);
    sda_low_o <= 1'b1;
    wt(HP);
    scl_o <= 1'b1;
    wt(HP);
    sda_low_o <= 1'b0;
    wt(HP);
  endtask

  task automatic write_byte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(b[i], s);
    end
    bit_x(1'b1, s);
    ack = ~s;
  endtask

  // The master acknowledges by holding the line low through the ninth clock.
  task automatic read_byte(input logic ack, output logic [7:0] d, output logic rel);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, s);
      d[i] = s;
    end
    bit_x(~ack, s);
    rel = s;
  endtask
endmodule

// ### bench/two_wire_register_read_slave_tb.sv
// Self-checking testbench for the two-wire register read slave.
// Assumes the bus master model and a word-wide register space held here.
`timescale 1ns/1ps
module two_wire_register_read_slave_tb;
  logic        clk_sys_i;
  logic        resetn_i;
  logic        scl;
  logic        sda_low;
  logic        sda_o;
  logic        sda_oe_o;
  logic [6:0]  reg_word_o;
  logic [15:0] reg_rdata_i;
  wire         sda_w;
  logic [15:0] mem [0:127];
  logic [31:0] seed = 32'h7936;
  int          n_mismatch = 0;
  int          check_count = 0;

  assign sda_w = ~sda_low & (~sda_oe_o | sda_o);
  assign reg_rdata_i = mem[reg_word_o];

  twr_read_slave i_twr_read_slave (
    .clk_sys_i   (clk_sys_i),
    .resetn_i    (resetn_i),
    .scl_i       (scl),
    .sda_i       (sda_w),
    .sda_o       (sda_o),
    .sda_oe_o    (sda_oe_o),
    .reg_word_o  (reg_word_o),
    .reg_rdata_i (reg_rdata_i)
  );

  twr_bus_master i_twr_bus_master (
    .clk_sys_i (clk_sys_i),
    .sda_i     (sda_w),
    .scl_o     (scl),
    .sda_low_o (sda_low)
  );

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction

  function automatic logic [7:0] exp_byte(input logic [8:0] a, input logic [15:0] w);
    if (a > 9'h0FF) begin
      return 8'hFF;
    end
    return a[0] ? w[7:0] : w[15:8];
  endfunction

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Data bytes after the pointer are discarded but still move it on.
  // With md set, the next word changes once its upper byte is fetched, which
  // checks that its lower byte still comes from the same sample.
  task automatic read_seq(input logic [7:0] ptr, input int n, input logic md, input logic rs,
                          input int nw);
    logic        a_ok;
    logic        rel;
    logic [7:0]  d;
    logic [8:0]  a;
    logic [15:0] w;
    logic [15:0] wn;
    logic [6:0]  k;
    i_twr_bus_master.start_c();
    i_twr_bus_master.write_byte(8'h6C, a_ok);
    chk("addr_w_ack", 16'(a_ok), 16'h0001);
    i_twr_bus_master.write_byte(ptr, a_ok);
    chk("ptr_ack", 16'(a_ok), 16'h0001);
    for (int j = 0; j < nw; j++) begin
      i_twr_bus_master.write_byte(8'(rnd()), a_ok);
      chk("wdata_ack", 16'(a_ok), 16'h0001);
    end
    i_twr_bus_master.start_c();
    i_twr_bus_master.write_byte(8'h6D, a_ok);
    chk("addr_r_ack", 16'(a_ok), 16'h0001);
    for (int i = 0; i < n; i++) begin
      a = {1'b0, ptr} + 9'(nw) + 9'(i);
      if (i == 0) begin
        w = mem[a[7:1]];
      end else if (!a[0]) begin
        w = wn;
      end
      i_twr_bus_master.read_byte(i < n - 1, d, rel);
      chk("rd_byte", 16'(d), 16'(exp_byte(a, w)));
      if (i == 0 || !a[0]) begin
        k = a[7:1] + 7'h01;
        wn = mem[k];
        if (md) begin
          mem[k] <= 16'(rnd());
        end
      end
    end
    chk("nak_release", 16'(rel), 16'h0001);
    if (rs) begin
      i_twr_bus_master.start_c();
    end
    i_twr_bus_master.stop_c();
  endtask

  task automatic bad_addr(input logic [7:0] b);
    logic a_ok;
    i_twr_bus_master.start_c();
    i_twr_bus_master.write_byte(b, a_ok);
    chk("bad_addr_ack", 16'(a_ok), 16'h0000);
    i_twr_bus_master.stop_c();
  endtask

  // ---------------------------------------------------------------------------
  // Clock, watchdog and sequence
  // ---------------------------------------------------------------------------
  initial begin
    clk_sys_i = 1'b0;
    forever #50 clk_sys_i = ~clk_sys_i;
  end

  // About fifteen reads of a few bytes need some 19000 to 27000 cycles.
  initial begin
    repeat (80000) @(posedge clk_sys_i);
    n_mismatch++;
    $display("[ERR] watchdog expected done seen timeout");
    test_done();
  end

  initial begin
    logic [7:0] b;
    resetn_i <= 1'b0;
    for (int i = 0; i < 128; i++) begin
      mem[i] = 16'(rnd());
    end
    repeat (5) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    chk("rst_oe", 16'(sda_oe_o), 16'h0000);
    read_seq(8'h10, 2, 1'b1, 1'b0, 0);
    read_seq(8'hFE, 4, 1'b0, 1'b1, 0);
    read_seq(8'h21, 3, 1'b1, 1'b0, 0);
    read_seq(8'hFF, 1, 1'b0, 1'b1, 0);
    read_seq(8'h31, 4, 1'b1, 1'b0, 1);
    read_seq(8'hFF, 2, 1'b0, 1'b0, 1);
    for (int k = 0; k < 4; k++) begin
      b = (k == 0) ? 8'h6E : 8'(rnd());
      if (b[7:1] == 7'h36) begin
        b = b ^ 8'h02;
      end
      bad_addr(b);
    end
    for (int k = 0; k < 8; k++) begin
      read_seq(8'(rnd()), 1 + int'(rnd() % 4), rnd() % 2 == 0, rnd() % 2 == 0, int'(rnd() % 2));
    end
    test_done();
  end
endmodule
